/* File: hw/sfpis_pkg.sv */
// constants, types and state records of the flash power/id/suspend sequencer
// assumes a 10 MHz core clock and a host that frames commands with select
package sfpis_pkg;

   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_DEEP_PD = 8'hB9;
   localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
   localparam logic [7:0] OP_MAKER_ID = 8'h90;
   localparam logic [7:0] OP_ID3 = 8'h9F;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7A;
   localparam logic [7:0] OP_UNIQUE = 8'h4B;
   localparam logic [7:0] OP_SEC_ERASE = 8'h44;
   localparam logic [7:0] OP_SEC_PROG = 8'h42;
   localparam logic [7:0] OP_STATUS_WR = 8'h01;
   localparam logic [7:0] OP_SECTOR_ER = 8'h20;
   localparam logic [7:0] OP_BLK32_ER = 8'h52;
   localparam logic [7:0] OP_BLK64_ER = 8'hD8;
   localparam logic [7:0] OP_CHIP_ER_A = 8'hC7;
   localparam logic [7:0] OP_CHIP_ER_B = 8'h60;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;

   // ----------------------------------------------------------------
   // frame bit counts and addresses
   // ----------------------------------------------------------------
   localparam logic [6:0] BITS_OP = 7'h08;
   localparam logic [6:0] BITS_ADDR_END = 7'h20;
   localparam logic [6:0] BITS_UID_END = 7'h28;
   localparam logic [6:0] CNT_MAX = 7'h7F;
   localparam logic [23:0] ADDR_ZERO = 24'h000000;
   localparam logic [23:0] ADDR_ONE = 24'h000001;
   localparam logic [3:0] SEC_REG_1 = 4'h1;
   localparam logic [3:0] SEC_REG_3 = 4'h3;
   localparam logic [7:0] LEN_ID1 = 8'h08;
   localparam logic [7:0] LEN_ID2 = 8'h10;
   localparam logic [7:0] LEN_ID3 = 8'h18;
   localparam logic [7:0] LEN_UID = 8'h80;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_DP_NS = 3000;
   localparam int T_RES1_NS = 30000;
   localparam int T_RES2_NS = 30000;
   localparam int T_RESUME_NS = 200;
   localparam int T_SE_NS = 1000000;
   // least times round up, the resume bound rounds down
   localparam logic [23:0] DP_CYC = 24'((T_DP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] RES1_CYC = 24'((T_RES1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] RES2_CYC = 24'((T_RES2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] RESUME_CYC = 2'(T_RESUME_NS / CLK_PERIOD_NS);
   localparam logic [23:0] SE_CYC_DFLT = 24'((T_SE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic si;
   } sfpis_pins_t;

   typedef enum logic [2:0] {
      SF_STANDBY,
      SF_DPD_ENTRY,
      SF_DPD,
      SF_RELEASE,
      SF_SEC_ERASE
   } sfpis_mode_t;

   typedef struct packed {
      sfpis_pins_t sync1;
      sfpis_pins_t sync2;
      sfpis_pins_t prev;
      logic [31:0] sh;
      logic [6:0] cnt;
      logic [7:0] op;
      logic op_ok;
      sfpis_mode_t mode;
      logic sus;
      logic armed;
      logic [1:0] resume_hold;
      logic write_in_progress;
      logic dpd;
      logic sec_busy;
      logic [1:0] sec_sel;
      logic wel_clr;
      logic sus_req;
      logic res_req;
      logic rst_pulse;
      logic rej;
   } sfpis_seq_t;

   typedef struct packed {
      logic [23:0] cnt;
      logic busy;
      logic done;
   } sfpis_tmr_t;

   typedef struct packed {
      logic [127:0] sr;
      logic [127:0] rel;
      logic [7:0] len;
      logic [7:0] cnt;
      logic act;
      logic so;
      logic oe_n;
   } sfpis_tx_t;

endpackage : sfpis_pkg

/* File: hw/sfpis_timer.sv */
// one-shot down counter for the self-timed delays of the sequencer
// assumes start and abort come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module sfpis_timer (
   input wire logic ref_clk_in, // core clock
   input wire logic nrst_in, // synchronous reset, active low
   input wire logic start_in, // load and run
   input wire logic [23:0] load_in, // cycles to run
   input wire logic abort_in, // stop without done
   output logic busy_out, // counting
   output logic done_out // one-cycle pulse at expiry
);
   sfpis_pkg::sfpis_tmr_t q, d;

   always_comb begin
      d = q;
      d.done = 1'b0;
      if (abort_in) begin
         d.busy = 1'b0;
         d.cnt = '0;
      end else if (start_in) begin
         d.busy = 1'b1;
         d.cnt = load_in;
      end else if (q.busy) begin
         if (q.cnt <= 24'h000001) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end else begin
            d.cnt = 24'(q.cnt - 24'h000001);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy_out = q.busy;
   assign done_out = q.done;
endmodule : sfpis_timer
`default_nettype wire

/* File: hw/sfpis_tx.sv */
// serial output shifter: msb first on each falling serial clock edge
// assumes edge and select strobes already synchronised to the core clock
`timescale 1ns/1ps
`default_nettype none
module sfpis_tx (
   input wire logic ref_clk_in, // core clock
   input wire logic nrst_in, // synchronous reset, active low
   input wire logic load_in, // take new pattern
   input wire logic [127:0] data_in, // pattern, msb aligned
   input wire logic [7:0] len_in, // pattern length in bits
   input wire logic fall_in, // falling serial clock edge seen
   input wire logic stop_in, // select high
   output logic so_out, // serial data
   output logic so_oe_n_out // low while driving
);
   sfpis_pkg::sfpis_tx_t q, d;

   always_comb begin
      d = q;
      if (stop_in) begin
         d.act = 1'b0;
         d.oe_n = 1'b1;
      end else if (load_in) begin
         d.sr = data_in;
         d.rel = data_in;
         d.len = len_in;
         d.cnt = '0;
         d.act = 1'b1;
      end else if (fall_in && q.act) begin
         d.so = q.sr[127];
         d.oe_n = 1'b0;
         if (q.cnt == 8'(q.len - 8'h01)) begin
            d.sr = q.rel;
            d.cnt = '0;
         end else begin
            d.sr = {q.sr[126:0], 1'b0};
            d.cnt = 8'(q.cnt + 8'h01);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         q <= '0;
         q.oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign so_out = q.so;
   assign so_oe_n_out = q.oe_n;
endmodule : sfpis_tx
`default_nettype wire

/* File: hw/sfpis_seq.sv */
// command sequencer for power-down, id reads, suspend/resume, unique id
// and security register erase of a serial nor flash
// assumes the array engine reports busy/suspendable and honours the requests
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - power-down only with select rising after eight bits
// - in power-down only release and reset pass
// - power-down entered after entry delay
// - power-down refused while a cycle runs
// - reset always lands in standby
// - release alone then wait release time
// - release plus dummies repeats device id
// - release ignored while write in progress
// - address zero gives maker then device byte
// - address one gives device then maker byte
// - three-byte id gives maker, type, capacity
// - three-byte id not decoded while busy
// - select high ends id output
// - suspend only during suspendable busy cycle
// - suspended device refuses writes and erases
// - suspend sets flag at once
// - resume clears flag, busy within 200ns
// - unique id after address and dummy
// - security erase needs latch, exact framing
// - security register selected by address bits
// - locked security registers refuse erase
// - reset aborts work and clears volatile state
module sfpis_seq #(
   parameter logic [23:0] SE_CYC = sfpis_pkg::SE_CYC_DFLT, // security erase cycles
   parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] DEV_ID = 8'h3C, // arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h61, // arbitrary value
   parameter logic [7:0] CAPACITY = 8'h12, // arbitrary value
   parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEFFEDCBA9876543210 // arbitrary value
) (
   input wire logic ref_clk_in, // core clock
   input wire logic nrst_in, // synchronous reset, active low
   input wire logic sclk_in, // serial clock pin
   input wire logic cs_n_in, // select pin, active low
   input wire logic si_in, // serial data in pin
   input wire logic array_busy_in, // program/erase/status write running
   input wire logic array_suspendable_in, // page program or sector/block erase running
   input wire logic write_enable_latch_in, // latch state
   input wire logic [2:0] security_lock_bits_in, // one-time locks, bit0 = register 1
   output logic so_out, // serial data out
   output logic so_oe_n_out, // low while driving so
   output logic write_in_progress_out, // busy flag
   output logic suspended_flags_out, // suspend flag
   output logic deep_power_down_out, // in power-down
   output logic wel_clear_out, // pulse: clear write enable latch
   output logic suspend_req_out, // pulse: halt array cycle
   output logic resume_req_out, // pulse: continue array cycle
   output logic sec_erase_busy_out, // security erase running
   output logic [1:0] sec_erase_sel_out, // register being erased, 1..3
   output logic array_cmd_block_out, // array writes refused
   output logic cmd_rejected_out, // pulse: opcode refused in suspend
   output logic soft_reset_out // pulse: reset command taken
);
   sfpis_pkg::sfpis_seq_t q, d;
   logic sclk_rise, sclk_fall, cs_rise;
   logic [7:0] op_now;
   logic ok_now;
   logic tmr_start, tmr_abort, tmr_busy, tmr_done;
   logic [23:0] tmr_load;
   logic tx_load;
   logic [127:0] tx_data;
   logic [7:0] tx_len;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic blocked(input logic [7:0] op);
      return op == sfpis_pkg::OP_STATUS_WR || op == sfpis_pkg::OP_SEC_ERASE ||
             op == sfpis_pkg::OP_SEC_PROG || op == sfpis_pkg::OP_SECTOR_ER ||
             op == sfpis_pkg::OP_BLK32_ER || op == sfpis_pkg::OP_BLK64_ER ||
             op == sfpis_pkg::OP_CHIP_ER_A || op == sfpis_pkg::OP_CHIP_ER_B;
   endfunction : blocked

   function automatic logic accept(input logic [7:0] op, input sfpis_pkg::sfpis_mode_t m,
                                   input logic write_in_progress, input logic sus, input logic armed);
      logic ok;
      ok = 1'b1;
      if (m == sfpis_pkg::SF_DPD_ENTRY || m == sfpis_pkg::SF_RELEASE) begin
         ok = 1'b0;
      end else if (m == sfpis_pkg::SF_DPD) begin
         ok = op == sfpis_pkg::OP_RELEASE_ID || op == sfpis_pkg::OP_RST_EN ||
              op == sfpis_pkg::OP_RST;
      end
      if (op == sfpis_pkg::OP_RELEASE_ID || op == sfpis_pkg::OP_ID3 ||
          op == sfpis_pkg::OP_DEEP_PD || op == sfpis_pkg::OP_SEC_ERASE) begin
         ok = ok && !write_in_progress;
      end
      if (op == sfpis_pkg::OP_RST) begin
         ok = ok && armed;
      end
      if (sus && blocked(op)) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : accept

   function automatic logic sec_addr_ok(input logic [23:0] a);
      return a[23:16] == 8'h00 && a[11:10] == 2'h0 &&
             a[15:12] >= sfpis_pkg::SEC_REG_1 && a[15:12] <= sfpis_pkg::SEC_REG_3;
   endfunction : sec_addr_ok

   function automatic logic locked(input logic [1:0] sel, input logic [2:0] lb);
      return lb[2'(sel - 2'h1)];
   endfunction : locked

   // ----------------------------------------------------------------
   // pin edges
   // ----------------------------------------------------------------
   // edges come from the second and third stages only
   assign sclk_rise = q.sync2.sclk && !q.prev.sclk;
   assign sclk_fall = !q.sync2.sclk && q.prev.sclk;
   assign cs_rise = q.sync2.cs_n && !q.prev.cs_n;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.sync1 = '{sclk: sclk_in, cs_n: cs_n_in, si: si_in};
      d.sync2 = q.sync1;
      d.prev = q.sync2;
      d.wel_clr = 1'b0;
      d.sus_req = 1'b0;
      d.res_req = 1'b0;
      d.rst_pulse = 1'b0;
      d.rej = 1'b0;
      op_now = q.op;
      ok_now = q.op_ok;
      tmr_start = 1'b0;
      tmr_abort = 1'b0;
      tmr_load = '0;
      tx_load = 1'b0;
      tx_data = '0;
      tx_len = '0;
      if (q.resume_hold != 2'h0) begin
         d.resume_hold = 2'(q.resume_hold - 2'h1);
      end
      if (q.sync2.cs_n) begin
         d.cnt = '0;
      end else if (sclk_rise && q.cnt != sfpis_pkg::CNT_MAX) begin
         d.sh = {q.sh[30:0], q.sync2.si};
         d.cnt = 7'(q.cnt + 7'h01);
         if (d.cnt == sfpis_pkg::BITS_OP) begin
            op_now = d.sh[7:0];
            ok_now = accept(op_now, q.mode, q.write_in_progress, q.sus, q.armed);
            d.op = op_now;
            d.op_ok = ok_now;
            d.rej = q.sus && blocked(op_now);
         end
         if (ok_now) begin
            if (d.cnt == sfpis_pkg::BITS_OP && op_now == sfpis_pkg::OP_ID3) begin
               tx_load = 1'b1;
               tx_data = {MFR_ID, MEM_TYPE, CAPACITY, 104'h0};
               tx_len = sfpis_pkg::LEN_ID3;
            end
            if (d.cnt == sfpis_pkg::BITS_ADDR_END && op_now == sfpis_pkg::OP_RELEASE_ID) begin
               tx_load = 1'b1;
               tx_data = {DEV_ID, 120'h0};
               tx_len = sfpis_pkg::LEN_ID1;
            end
            if (d.cnt == sfpis_pkg::BITS_ADDR_END && op_now == sfpis_pkg::OP_MAKER_ID) begin
               tx_load = 1'b1;
               tx_data = (d.sh[23:0] == sfpis_pkg::ADDR_ONE) ? {DEV_ID, MFR_ID, 112'h0}
                                                             : {MFR_ID, DEV_ID, 112'h0};
               tx_len = sfpis_pkg::LEN_ID2;
            end
            // unique id after address and dummy
            if (d.cnt == sfpis_pkg::BITS_UID_END && op_now == sfpis_pkg::OP_UNIQUE) begin
               tx_load = 1'b1;
               tx_data = UNIQUE_ID;
               tx_len = sfpis_pkg::LEN_UID;
            end
         end
      end

      // end-of-frame commands
      if (cs_rise) begin
         if (q.cnt != 7'h00) begin
            d.armed = 1'b0;
         end
         if (q.op_ok) begin
            if (q.op == sfpis_pkg::OP_DEEP_PD && q.cnt == sfpis_pkg::BITS_OP && !q.write_in_progress) begin
               d.mode = sfpis_pkg::SF_DPD_ENTRY;
               tmr_start = 1'b1;
               tmr_load = sfpis_pkg::DP_CYC;
            end
            if (q.op == sfpis_pkg::OP_RELEASE_ID && q.mode == sfpis_pkg::SF_DPD) begin
               if (q.cnt == sfpis_pkg::BITS_OP) begin
                  d.mode = sfpis_pkg::SF_RELEASE;
                  tmr_start = 1'b1;
                  tmr_load = sfpis_pkg::RES1_CYC;
               end else if (q.cnt >= sfpis_pkg::BITS_ADDR_END) begin
                  d.mode = sfpis_pkg::SF_RELEASE;
                  tmr_start = 1'b1;
                  tmr_load = sfpis_pkg::RES2_CYC;
               end
            end
            if (q.op == sfpis_pkg::OP_RST_EN && q.cnt == sfpis_pkg::BITS_OP) begin
               d.armed = 1'b1;
            end
            if (q.op == sfpis_pkg::OP_SUSPEND && q.cnt == sfpis_pkg::BITS_OP &&
                q.write_in_progress && !q.sus && array_suspendable_in) begin
               d.sus = 1'b1;
               d.sus_req = 1'b1;
            end
            // resume, busy held for the gap
            if (q.op == sfpis_pkg::OP_RESUME && q.cnt == sfpis_pkg::BITS_OP &&
                q.sus && !q.write_in_progress) begin
               d.sus = 1'b0;
               d.res_req = 1'b1;
               d.resume_hold = sfpis_pkg::RESUME_CYC;
            end
            if (q.op == sfpis_pkg::OP_SEC_ERASE && q.cnt == sfpis_pkg::BITS_ADDR_END &&
                write_enable_latch_in && !q.write_in_progress && !q.sus && sec_addr_ok(q.sh[23:0]) &&
                !locked(q.sh[13:12], security_lock_bits_in)) begin
               d.mode = sfpis_pkg::SF_SEC_ERASE;
               d.sec_sel = q.sh[13:12];
               tmr_start = 1'b1;
               tmr_load = SE_CYC;
            end
         end
      end

      if (tmr_done) begin
         if (q.mode == sfpis_pkg::SF_DPD_ENTRY) begin
            d.mode = sfpis_pkg::SF_DPD;
         end else if (q.mode == sfpis_pkg::SF_RELEASE || q.mode == sfpis_pkg::SF_SEC_ERASE) begin
            d.mode = sfpis_pkg::SF_STANDBY;
         end
         // latch cleared in the same cycle the erase ends and busy drops
         d.wel_clr = q.mode == sfpis_pkg::SF_SEC_ERASE;
      end

      if (cs_rise && q.op_ok && q.op == sfpis_pkg::OP_RST && q.cnt == sfpis_pkg::BITS_OP) begin
         d.mode = sfpis_pkg::SF_STANDBY;
         d.sus = 1'b0;
         d.armed = 1'b0;
         d.resume_hold = 2'h0;
         d.wel_clr = 1'b1;
         d.rst_pulse = 1'b1;
         tmr_abort = 1'b1;
         tmr_start = 1'b0;
      end

      d.write_in_progress = array_busy_in || d.mode == sfpis_pkg::SF_SEC_ERASE || d.resume_hold != 2'h0;
      d.dpd = d.mode == sfpis_pkg::SF_DPD;
      d.sec_busy = d.mode == sfpis_pkg::SF_SEC_ERASE;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   sfpis_timer u_timer (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .start_in(tmr_start),
      .load_in(tmr_load),
      .abort_in(tmr_abort),
      .busy_out(tmr_busy),
      .done_out(tmr_done)
   );

   sfpis_tx u_tx (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .load_in(tx_load),
      .data_in(tx_data),
      .len_in(tx_len),
      .fall_in(sclk_fall),
      .stop_in(q.sync2.cs_n),
      .so_out(so_out),
      .so_oe_n_out(so_oe_n_out)
   );

   assign write_in_progress_out = q.write_in_progress;
   assign suspended_flags_out = q.sus;
   assign deep_power_down_out = q.dpd;
   assign wel_clear_out = q.wel_clr;
   assign suspend_req_out = q.sus_req;
   assign resume_req_out = q.res_req;
   assign sec_erase_busy_out = q.sec_busy;
   assign sec_erase_sel_out = q.sec_sel;
   assign array_cmd_block_out = q.sus;
   assign cmd_rejected_out = q.rej;
   assign soft_reset_out = q.rst_pulse;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   localparam int RES_WAIT_MAX = 400;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_entry_hold;
      (q.mode == sfpis_pkg::SF_DPD_ENTRY && !q.dpd) [*8];
   endsequence
   sequence s_release_hold;
      (q.mode == sfpis_pkg::SF_RELEASE) [*8];
   endsequence

   chk_dpd_from_entry: assert property ($rose(q.dpd) |-> $past(q.mode) == sfpis_pkg::SF_DPD_ENTRY)
      else $error("power-down entered without entry phase");
   chk_dpd_entry_delay: assert property ($rose(q.mode == sfpis_pkg::SF_DPD_ENTRY) |-> s_entry_hold)
      else $error("power-down entered too early");
   chk_dpd_filter: assert property (q.mode == sfpis_pkg::SF_DPD && sclk_rise && !q.sync2.cs_n && d.cnt == sfpis_pkg::BITS_OP && d.sh[7:0] != sfpis_pkg::OP_RELEASE_ID && d.sh[7:0] != sfpis_pkg::OP_RST_EN && d.sh[7:0] != sfpis_pkg::OP_RST |=> !q.op_ok)
      else $error("command accepted in power-down");
   chk_dpd_busy_reject: assert property ($rose(q.mode == sfpis_pkg::SF_DPD_ENTRY) |-> !$past(q.write_in_progress))
      else $error("power-down taken while busy");
   chk_reset_standby: assert property (@(posedge ref_clk_in) $past(!nrst_in) |-> q.mode == sfpis_pkg::SF_STANDBY && !deep_power_down_out)
      else $error("reset did not give standby");
   chk_release_wait: assert property ($rose(q.mode == sfpis_pkg::SF_RELEASE) |-> s_release_hold ##[1:RES_WAIT_MAX] q.mode == sfpis_pkg::SF_STANDBY)
      else $error("release time wrong");
   chk_release_busy: assert property (q.write_in_progress && sclk_rise && !q.sync2.cs_n && d.cnt == sfpis_pkg::BITS_OP && d.sh[7:0] == sfpis_pkg::OP_RELEASE_ID |=> !q.op_ok)
      else $error("release accepted while busy");
   chk_suspend_cond: assert property ($rose(q.sus) |-> $past(q.write_in_progress) && $past(array_suspendable_in) && suspend_req_out)
      else $error("suspend taken without busy cycle");
   chk_resume_busy: assert property (resume_req_out |-> !q.sus ##0 (write_in_progress_out [*2]))
      else $error("resume did not show busy");
   chk_sec_lock: assert property ($rose(q.sec_busy) |-> !locked(q.sec_sel, $past(security_lock_bits_in)) && $past(write_enable_latch_in))
      else $error("security erase on locked register");
   chk_soft_reset: assert property (soft_reset_out |-> !q.sus && q.mode == sfpis_pkg::SF_STANDBY && wel_clear_out)
      else $error("reset left volatile state");
endmodule : sfpis_seq
`default_nettype wire

/* File: tb/sfpis_host.sv */
// host model: frames commands on the serial link
// assumes the 10 MHz core clock paces the 800 ns link clock
`timescale 1ns/1ps
`default_nettype none
module sfpis_host (
   input wire logic clk_in, // core clock
   input wire logic so_in, // device data
   output logic sclk_out, // link clock
   output logic cs_n_out, // select, active low
   output logic si_out // host data
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
   end
   // select rises four core clocks after last bit
   task automatic xfer(input logic [39:0] tx, input int n, output logic [127:0] rx);
      rx = '0;
      @(negedge clk_in);
      cs_n_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_out = (i < 40) ? tx[39 - i] : ~si_out;
         repeat (4) @(negedge clk_in);
         sclk_out = 1'b1;
         repeat (4) @(negedge clk_in);
         rx = {rx[126:0], so_in};
         sclk_out = 1'b0;
      end
      repeat (4) @(negedge clk_in);
      cs_n_out = 1'b1;
      repeat (8) @(negedge clk_in);
   endtask : xfer
endmodule : sfpis_host
`default_nettype wire

/* File: tb/sfpis_seq_tb_top.sv */
// bench for the power-down, id and suspend sequencer
// assumes the host model drives the link
`timescale 1ns/1ps
`default_nettype none
module sfpis_seq_tb_top;
   logic clk, nrst, bsy, spd, write_enable_latch;
   logic [2:0] lk;
   logic [127:0] r;
   logic sclk, cs_n, si, so, sus, dpd, seb, write_in_progress;
   int fails = 0;
   int n_compared = 0;
   // ids: arbitrary values
   localparam logic [127:0] UID = 128'hC3A5_0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2;
   sfpis_seq #(.SE_CYC(24'h000032), .MFR_ID(8'hA1), .DEV_ID(8'h4D), .MEM_TYPE(8'h72),
      .CAPACITY(8'h18), .UNIQUE_ID(UID)) u_sfpis_seq (.ref_clk_in(clk), .nrst_in(nrst),
      .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .array_busy_in(bsy),
      .array_suspendable_in(spd), .write_enable_latch_in(write_enable_latch), .security_lock_bits_in(lk),
      .so_out(so), .so_oe_n_out(), .write_in_progress_out(write_in_progress), .suspended_flags_out(sus),
      .deep_power_down_out(dpd), .wel_clear_out(), .suspend_req_out(), .resume_req_out(),
      .sec_erase_busy_out(seb), .sec_erase_sel_out(), .array_cmd_block_out(),
      .cmd_rejected_out(), .soft_reset_out());
   sfpis_host u_sfpis_host (.clk_in(clk), .so_in(so), .sclk_out(sclk), .cs_n_out(cs_n),
      .si_out(si));
   task automatic chk(input logic [127:0] g, input logic [127:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic tx(input logic [39:0] c, input int n);
      u_sfpis_host.xfer(c, n, r);
   endtask : tx
   task automatic t_ids;
      tx(40'h9F_0000_0000, 32); chk(r[23:0], 24'hA1_72_18);
      tx(40'h90_0000_0000, 48); chk(r[15:0], 16'hA1_4D);
      tx(40'h90_0000_0100, 48); chk(r[15:0], 16'h4D_A1);
      tx(40'hAB_0000_0000, 48); chk(r[15:0], 16'h4D_4D);
      tx(40'h4B_0000_0000, 168); chk(r, UID);
      $display("test ids done");
   endtask : t_ids
   task automatic t_dpd;
      tx(40'hB9_0000_0000, 9); repeat (40) @(negedge clk); chk(dpd, 1'b0);
      tx(40'hB9_0000_0000, 8); repeat (40) @(negedge clk); chk(dpd, 1'b1);
      tx(40'h9F_0000_0000, 32); chk(dpd, 1'b1);
      tx(40'hAB_0000_0000, 8); repeat (310) @(negedge clk); chk(dpd, 1'b0);
      $display("test power-down done");
   endtask : t_dpd
   task automatic t_sus;
      bsy = 1'b1; spd = 1'b1; write_enable_latch = 1'b1;
      tx(40'hB9_0000_0000, 8); repeat (40) @(negedge clk); chk(dpd, 1'b0);
      tx(40'h75_0000_0000, 8); chk(sus, 1'b1);
      bsy = 1'b0;
      tx(40'h44_0010_0000, 32); chk(seb, 1'b0);
      tx(40'h7A_0000_0000, 8); chk(sus, 1'b0);
      $display("test suspend done");
   endtask : t_sus
   task automatic t_se;
      lk = 3'b001;
      tx(40'h44_0010_0000, 32); chk(seb, 1'b0);
      tx(40'h44_0020_0000, 32); chk(seb, 1'b1);
      chk(write_in_progress, 1'b1);
      repeat (60) @(negedge clk); chk(seb, 1'b0);
      bsy = 1'b1; spd = 1'b1;
      tx(40'h75_0000_0000, 8); chk(sus, 1'b1);
      bsy = 1'b0;
      tx(40'h66_0000_0000, 8); tx(40'h99_0000_0000, 8); chk(sus, 1'b0);
      $display("test erase done");
   endtask : t_se
   task automatic results;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      nrst = 1'b0; bsy = 1'b0; spd = 1'b0; write_enable_latch = 1'b0; lk = 3'b000;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      chk(dpd, 1'b0);
      t_ids; t_dpd; t_sus; t_se;
      results;
   end
   // hang guard: tests need well under 2 ms
   initial begin
      #2000000;
      fails++;
      results;
   end
endmodule : sfpis_seq_tb_top
`default_nettype wire
